/* pkg/dsos_defines.svh */
// Constants for the daily switch output scheduler
`ifndef DSOS_DEFINES_SVH
`define DSOS_DEFINES_SVH
`define DSOS_ADDR_STATUS 4'h0
`define DSOS_ADDR_CONFIG 4'h4
`define DSOS_CFG_MODE1 1:0
`define DSOS_CFG_MODE2 3:2
`define DSOS_CFG_OPEN 4
`define DSOS_ST_SW1 0
`define DSOS_ST_SW2 1
`define DSOS_ST_UNSET 2
`define DSOS_ST_STATE 7:4
`define DSOS_HOURS 6'h18
`define DSOS_MINSEC 6'h3c
`define DSOS_CHARS 6'h24
`define DSOS_CODE_ZERO 24'h000000
`define DSOS_FIELD_LAST 2'h2
`define DSOS_SUB_ONE 3'h2
`define DSOS_SUB_TWO 3'h4
`define DSOS_SUB_ACCESS 3'h1
`define DSOS_ITEM_ACCESS 2'h2
`define DSOS_ITEM_LOCK 2'h3
`define DSOS_SLOT_ON1 0
`define DSOS_SLOT_OFF1 1
`define DSOS_SLOT_ON2 2
`define DSOS_SLOT_OFF2 3
`endif

/* pkg/dsos_pkg.sv */
// Types for the daily switch output scheduler
package dsos_pkg;
  typedef enum logic [1:0] {
    DSOS_OFF = 2'b00,
    DSOS_ONE = 2'b01,
    DSOS_TWO = 2'b10
  } dsos_mode_t;
  typedef struct packed {
    logic [4:0] h;
    logic [5:0] m;
    logic [5:0] s;
  } dsos_hms_t;
  typedef enum logic [3:0] {
    DSOS_S_DISP = 4'b0000,
    DSOS_S_LOCK = 4'b0001,
    DSOS_S_MENU = 4'b0010,
    DSOS_S_SUB = 4'b0011,
    DSOS_S_EN = 4'b0100,
    DSOS_S_TIME = 4'b0101,
    DSOS_S_CODE = 4'b0110,
    DSOS_S_OPCODE = 4'b0111,
    DSOS_S_OPSEL = 4'b1000
  } dsos_state_t;
endpackage

/* logic/dsos_time_cmp.sv */
// Per-output time-of-day comparator and switch state
`timescale 1ns/1ps
`default_nettype none
`include "dsos_defines.svh"
module dsos_time_cmp
  import dsos_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sec_tick,
  input wire dsos_hms_t tod,
  input wire dsos_mode_t mode,
  input wire dsos_hms_t [3:0] times,
  output logic sw_r
);
  // Off wins when on and off times coincide, so a bad setup fails open
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sw_r <= 1'b0;
    else
    begin
      unique case (mode)
        DSOS_OFF: sw_r <= 1'b0;
        DSOS_ONE:
        begin
          if (sec_tick && tod == times[`DSOS_SLOT_OFF1])
            sw_r <= 1'b0;
          else if (sec_tick && tod == times[`DSOS_SLOT_ON1])
            sw_r <= 1'b1;
        end
        DSOS_TWO:
        begin
          if (sec_tick && (tod == times[`DSOS_SLOT_OFF1] ||
              tod == times[`DSOS_SLOT_OFF2]))
            sw_r <= 1'b0;
          else if (sec_tick && (tod == times[`DSOS_SLOT_ON1] ||
                   tod == times[`DSOS_SLOT_ON2]))
            sw_r <= 1'b1;
        end
        default: sw_r <= 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* logic/dsos_sched.sv */
// Daily switch output scheduler with menu, codes and registers
`timescale 1ns/1ps
`default_nettype none
`include "dsos_defines.svh"
module dsos_sched
  import dsos_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic btn_prog,
  input wire logic btn_enter,
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic sec_tick,
  input wire dsos_hms_t tod,
  input wire logic time_set,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [DATA_W-1:0] bus_rdata_r,
  output logic first_switch_output,
  output logic second_switch_output,
  output logic first_indicator,
  output logic second_indicator,
  output logic clock_unset_r,
  output dsos_state_t state_r
);
  if (ADDR_W < 3 || DATA_W < 8)
  begin : g_chk
    $error("dsos_sched: bus too narrow");
  end

  logic [1:0] item_r;
  logic [2:0] sub_r;
  logic [2:0] sel_r;
  logic [2:0] tidx_r;
  logic [1:0] field_r;
  logic ret_op_r;
  logic [1:0] pos_r;
  logic [23:0] ent_r;
  logic [23:0] lock_r;
  logic [23:0] lockp_r;
  logic [23:0] acc_r;
  logic [23:0] accp_r;
  dsos_mode_t [1:0] mode_r;
  logic op_en_r;
  dsos_hms_t [7:0] times_r;
  logic [1:0] sw;

  function automatic logic [5:0] step(input logic [5:0] v,
                                      input logic [5:0] lim,
                                      input logic up);
    if (up)
      return (v == lim - 6'h1) ? 6'h0 : v + 6'h1;
    return (v == 6'h0) ? lim - 6'h1 : v - 6'h1;
  endfunction

  function automatic logic [2:0] sub_max(input dsos_mode_t m);
    unique case (m)
      DSOS_ONE: return `DSOS_SUB_ONE;
      DSOS_TWO: return `DSOS_SUB_TWO;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic slot_ok(input logic [2:0] s,
                                   input dsos_mode_t m0,
                                   input dsos_mode_t m1);
    dsos_mode_t m;
    m = s[2] ? m1 : m0;
    unique case (m)
      DSOS_ONE: return !s[1];
      DSOS_TWO: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Walks to the next slot the operator may see, skipping hidden ones
  function automatic logic [2:0] next_slot(input logic [2:0] s,
                                           input logic up,
                                           input dsos_mode_t m0,
                                           input dsos_mode_t m1);
    logic [2:0] c;
    logic [2:0] r;
    logic f;
    c = s;
    r = s;
    f = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      c = up ? c + 3'h1 : c - 3'h1;
      if (!f && slot_ok(c, m0, m1))
      begin
        r = c;
        f = 1'b1;
      end
    end
    return r;
  endfunction

  logic pe;
  logic pu;
  logic up_dn;
  logic lock_zero;
  logic acc_zero;
  logic [2:0] first_slot;
  logic first_ok;
  logic [2:0] smax;
  logic [2:0] sm1;
  logic in_code;
  logic [5:0] cur_ch;
  logic [5:0] fv;
  logic [5:0] flim;
  logic [5:0] fnv;

  assign pe = btn_prog & btn_enter;
  assign pu = btn_prog & btn_up;
  assign up_dn = (btn_up ^ btn_down) & ~btn_prog & ~btn_enter;
  assign lock_zero = lock_r == `DSOS_CODE_ZERO;
  assign acc_zero = acc_r == `DSOS_CODE_ZERO;
  assign first_slot = next_slot(3'h7, 1'b1, mode_r[0], mode_r[1]);
  assign first_ok = slot_ok(first_slot, mode_r[0], mode_r[1]);
  assign smax = (item_r == `DSOS_ITEM_ACCESS) ? `DSOS_SUB_ACCESS :
                sub_max(mode_r[item_r[0]]);
  assign sm1 = sub_r - 3'h1;
  assign in_code = state_r == DSOS_S_LOCK || state_r == DSOS_S_OPCODE ||
                   state_r == DSOS_S_CODE;
  assign cur_ch = ent_r[6*pos_r +: 6];

  always_comb
  begin
    fv = {1'b0, times_r[tidx_r].h};
    flim = `DSOS_HOURS;
    if (field_r == 2'h1)
    begin
      fv = times_r[tidx_r].m;
      flim = `DSOS_MINSEC;
    end
    else if (field_r == `DSOS_FIELD_LAST)
    begin
      fv = times_r[tidx_r].s;
      flim = `DSOS_MINSEC;
    end
    fnv = step(fv, flim, btn_up);
  end

  // Menu navigation
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_r <= DSOS_S_DISP;
      item_r <= 2'h0;
      sub_r <= 3'h0;
      sel_r <= 3'h0;
      tidx_r <= 3'h0;
      field_r <= 2'h0;
      ret_op_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        DSOS_S_DISP:
        begin
          if (pe)
          begin
            state_r <= lock_zero ? DSOS_S_MENU : DSOS_S_LOCK;
            item_r <= 2'h0;
          end
          else if (pu && op_en_r)
          begin
            if (!acc_zero)
              state_r <= DSOS_S_OPCODE;
            else if (first_ok)
            begin
              state_r <= DSOS_S_OPSEL;
              sel_r <= first_slot;
            end
          end
        end
        DSOS_S_LOCK:
          if (btn_enter)
            state_r <= (ent_r == lock_r) ? DSOS_S_MENU : DSOS_S_DISP;
        DSOS_S_OPCODE:
          if (btn_enter)
          begin
            if (ent_r == acc_r && first_ok)
            begin
              state_r <= DSOS_S_OPSEL;
              sel_r <= first_slot;
            end
            else
              state_r <= DSOS_S_DISP;
          end
        DSOS_S_MENU:
        begin
          if (btn_enter)
            state_r <= DSOS_S_DISP;
          else if (btn_prog)
          begin
            state_r <= (item_r == `DSOS_ITEM_LOCK) ? DSOS_S_CODE : DSOS_S_SUB;
            sub_r <= 3'h0;
          end
          else if (up_dn)
            item_r <= btn_up ? item_r + 2'h1 : item_r - 2'h1;
        end
        DSOS_S_SUB:
        begin
          if (btn_enter)
            state_r <= DSOS_S_MENU;
          else if (btn_prog)
          begin
            if (sub_r == 3'h0)
              state_r <= DSOS_S_EN;
            else if (item_r == `DSOS_ITEM_ACCESS)
              state_r <= DSOS_S_CODE;
            else
            begin
              state_r <= DSOS_S_TIME;
              tidx_r <= {item_r[0], sm1[1:0]};
              field_r <= 2'h0;
              ret_op_r <= 1'b0;
            end
          end
          else if (up_dn)
          begin
            // Hidden time settings are never reachable here
            if (btn_up)
              sub_r <= (sub_r >= smax) ? 3'h0 : sub_r + 3'h1;
            else
              sub_r <= (sub_r == 3'h0) ? smax : sub_r - 3'h1;
          end
        end
        DSOS_S_EN:
          if (btn_enter)
          begin
            state_r <= DSOS_S_SUB;
            sub_r <= 3'h0;
          end
        DSOS_S_TIME:
        begin
          if (btn_enter)
            state_r <= ret_op_r ? DSOS_S_OPSEL : DSOS_S_SUB;
          else if (btn_prog)
            field_r <= (field_r == `DSOS_FIELD_LAST) ? 2'h0 :
                       field_r + 2'h1;
        end
        DSOS_S_CODE:
          if (btn_enter)
            state_r <= (item_r == `DSOS_ITEM_ACCESS) ? DSOS_S_SUB :
                       DSOS_S_MENU;
        DSOS_S_OPSEL:
        begin
          if (btn_enter)
            state_r <= DSOS_S_DISP;
          else if (btn_prog)
          begin
            state_r <= DSOS_S_TIME;
            tidx_r <= sel_r;
            field_r <= 2'h0;
            ret_op_r <= 1'b1;
          end
          else if (up_dn)
            sel_r <= next_slot(sel_r, btn_up, mode_r[0], mode_r[1]);
        end
        default: state_r <= DSOS_S_DISP;
      endcase
    end
  end

  // Codes: pending values are edited, active values follow in display
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      lock_r <= `DSOS_CODE_ZERO;
      lockp_r <= `DSOS_CODE_ZERO;
      acc_r <= `DSOS_CODE_ZERO;
      accp_r <= `DSOS_CODE_ZERO;
      ent_r <= `DSOS_CODE_ZERO;
      pos_r <= 2'h0;
    end
    else
    begin
      if (state_r == DSOS_S_DISP)
      begin
        lock_r <= lockp_r;
        acc_r <= accp_r;
      end
      if (state_r == DSOS_S_DISP && (pe || pu))
      begin
        ent_r <= `DSOS_CODE_ZERO;
        pos_r <= 2'h0;
      end
      else if (state_r == DSOS_S_MENU && !btn_enter && btn_prog &&
               item_r == `DSOS_ITEM_LOCK)
      begin
        ent_r <= lockp_r;
        pos_r <= 2'h0;
      end
      else if (state_r == DSOS_S_SUB && !btn_enter && btn_prog &&
               item_r == `DSOS_ITEM_ACCESS && sub_r != 3'h0)
      begin
        ent_r <= accp_r;
        pos_r <= 2'h0;
      end
      else if (in_code)
      begin
        if (btn_enter)
        begin
          if (state_r == DSOS_S_CODE && item_r == `DSOS_ITEM_LOCK)
            lockp_r <= ent_r;
          else if (state_r == DSOS_S_CODE)
            accp_r <= ent_r;
        end
        else if (btn_prog)
          pos_r <= pos_r + 2'h1;
        else if (up_dn)
          ent_r[6*pos_r +: 6] <= step(cur_ch, `DSOS_CHARS, btn_up);
      end
    end
  end

  // Enable settings; a bus write takes priority over the menu
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mode_r[0] <= DSOS_OFF;
      mode_r[1] <= DSOS_OFF;
      op_en_r <= 1'b0;
    end
    else if (bus_wr && bus_addr == `DSOS_ADDR_CONFIG)
    begin
      mode_r[0] <= dsos_mode_t'(bus_wdata[`DSOS_CFG_MODE1]);
      mode_r[1] <= dsos_mode_t'(bus_wdata[`DSOS_CFG_MODE2]);
      op_en_r <= bus_wdata[`DSOS_CFG_OPEN];
    end
    else if (state_r == DSOS_S_EN && up_dn)
    begin
      if (item_r == `DSOS_ITEM_ACCESS)
        op_en_r <= ~op_en_r;
      else
        unique case (mode_r[item_r[0]])
          DSOS_OFF: mode_r[item_r[0]] <= btn_up ? DSOS_ONE : DSOS_TWO;
          DSOS_ONE: mode_r[item_r[0]] <= btn_up ? DSOS_TWO : DSOS_OFF;
          default: mode_r[item_r[0]] <= btn_up ? DSOS_OFF : DSOS_ONE;
        endcase
    end
  end

  // Stored times live apart from the enables, so enables never touch them
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      times_r <= '0;
    else if (state_r == DSOS_S_TIME && up_dn)
    begin
      unique case (field_r)
        2'h0: times_r[tidx_r].h <= fnv[4:0];
        2'h1: times_r[tidx_r].m <= fnv;
        default: times_r[tidx_r].s <= fnv;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      clock_unset_r <= 1'b1;
    else if (time_set)
      clock_unset_r <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      bus_rdata_r <= '0;
    else
    begin
      bus_rdata_r <= '0;
      if (bus_rd && bus_addr == `DSOS_ADDR_STATUS)
      begin
        bus_rdata_r[`DSOS_ST_SW1] <= sw[0];
        bus_rdata_r[`DSOS_ST_SW2] <= sw[1];
        bus_rdata_r[`DSOS_ST_UNSET] <= clock_unset_r;
        bus_rdata_r[`DSOS_ST_STATE] <= state_r;
      end
      else if (bus_rd && bus_addr == `DSOS_ADDR_CONFIG)
      begin
        bus_rdata_r[`DSOS_CFG_MODE1] <= mode_r[0];
        bus_rdata_r[`DSOS_CFG_MODE2] <= mode_r[1];
        bus_rdata_r[`DSOS_CFG_OPEN] <= op_en_r;
      end
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_out
    dsos_time_cmp u_cmp (
      .clk_sys(clk_sys),
      .srst(srst),
      .sec_tick(sec_tick),
      .tod(tod),
      .mode(mode_r[g]),
      .times(times_r[4*g +: 4]),
      .sw_r(sw[g])
    );
  end

  // Switch and its lamp share one flop so they can never disagree
  assign first_switch_output = sw[0];
  assign second_switch_output = sw[1];
  assign first_indicator = sw[0];
  assign second_indicator = sw[1];

  a_disabled_open:
    assert property (@(posedge clk_sys) disable iff (srst)
      mode_r[0] == DSOS_OFF |=> !sw[0])
    else $error("disabled output closed");
  a_on_match_closes:
    assert property (@(posedge clk_sys) disable iff (srst)
      sec_tick && (mode_r[1] == DSOS_ONE || mode_r[1] == DSOS_TWO)
      && tod == times_r[4] && tod != times_r[5]
      && (mode_r[1] != DSOS_TWO || tod != times_r[7])
      && $stable(mode_r[1]) |=> sw[1])
    else $error("on match did not close");
  a_one_pair_only:
    assert property (@(posedge clk_sys) disable iff (srst)
      mode_r[0] == DSOS_ONE && $stable(mode_r[0]) && sw[0]
      && !(sec_tick && (tod == times_r[1] || tod == times_r[0]))
      |=> sw[0])
    else $error("second pair used in one pair mode");
  a_sub_hidden:
    assert property (@(posedge clk_sys) disable iff (srst)
      state_r == DSOS_S_SUB && item_r != `DSOS_ITEM_ACCESS
      |-> sub_r <= sub_max(mode_r[item_r[0]]))
    else $error("hidden time setting offered");
  a_en_keeps_times:
    assert property (@(posedge clk_sys) disable iff (srst)
      state_r == DSOS_S_EN |=> times_r == $past(times_r))
    else $error("enable edit changed a time");
  a_field_order:
    assert property (@(posedge clk_sys) disable iff (srst)
      state_r == DSOS_S_TIME && field_r == 2'h0 && btn_prog && !btn_enter
      |=> state_r == DSOS_S_TIME && field_r == 2'h1)
    else $error("field did not go hours to minutes");
  a_edit_from_hours:
    assert property (@(posedge clk_sys) disable iff (srst)
      state_r == DSOS_S_TIME && $past(state_r) != DSOS_S_TIME
      |-> field_r == 2'h0)
    else $error("time edit did not start at hours");
  a_lamp_follows:
    assert property (@(posedge clk_sys) disable iff (srst)
      first_indicator == first_switch_output
      && second_indicator == second_switch_output)
    else $error("indicator differs from switch");
  a_op_entry:
    assert property (@(posedge clk_sys) disable iff (srst)
      state_r == DSOS_S_DISP && !pe && pu && op_en_r && acc_zero
      && first_ok |=> state_r == DSOS_S_OPSEL)
    else $error("operator menu not opened");
  a_op_code_gate:
    assert property (@(posedge clk_sys) disable iff (srst)
      state_r == DSOS_S_DISP && !pe && pu && op_en_r && !acc_zero
      |=> state_r == DSOS_S_OPCODE)
    else $error("operator code skipped");
  a_lock_gate:
    assert property (@(posedge clk_sys) disable iff (srst)
      state_r == DSOS_S_DISP && pe
      |=> state_r == ($past(lock_zero) ? DSOS_S_MENU : DSOS_S_LOCK))
    else $error("lock code gate wrong");
  a_code_digit:
    assert property (@(posedge clk_sys) disable iff (srst)
      in_code && btn_prog && !btn_enter |=> pos_r == $past(pos_r) + 2'h1)
    else $error("code position did not advance");
  a_code_deferred:
    assert property (@(posedge clk_sys) disable iff (srst)
      state_r != DSOS_S_DISP |=> lock_r == $past(lock_r))
    else $error("lock code changed inside menu");
  a_unset_holds:
    assert property (@(posedge clk_sys) disable iff (srst)
      clock_unset_r && !time_set |=> clock_unset_r)
    else $error("clock unset cleared without set time");
endmodule
`default_nettype wire

/* tb/dsos_panel.sv */
// Front panel buttons and switched loads facing the scheduler
`timescale 1ns/1ps
`default_nettype none
module dsos_panel
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] press_req,
  input wire logic load1_drive,
  input wire logic load2_drive,
  output logic btn_prog,
  output logic btn_enter,
  output logic btn_up,
  output logic btn_down,
  output logic [1:0] load_on_r,
  output logic [7:0] n_close_r
);
  // One press is one cycle; buttons rest released between requests
  always_ff @(posedge clk_sys)
  begin
    {btn_prog, btn_enter, btn_up, btn_down} <= srst ? 4'h0 : press_req;
  end
  // Loads only see the contacts; closures of load one are counted
  always_ff @(posedge clk_sys)
  begin
    load_on_r <= {load2_drive, load1_drive};
    if (srst)
      n_close_r <= 8'h00;
    else if (load1_drive && !load_on_r[0])
      n_close_r <= n_close_r + 8'h01;
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the daily switch output scheduler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dsos_pkg::*;
  localparam logic [3:0] P = 4'h8;
  localparam logic [3:0] E = 4'h4;
  localparam logic [3:0] U = 4'h2;
  localparam logic [3:0] D = 4'h1;
  localparam logic [16:0] T_ON1 = {5'h02, 6'h01, 6'h00};
  localparam logic [16:0] T_OFF1 = {5'h03, 6'h00, 6'h00};
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic sec_tick = 1'b0;
  logic time_set = 1'b0;
  dsos_hms_t tod = 17'h00000;
  logic [3:0] bus_addr = 4'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [3:0] press_req = 4'h0;
  logic [31:0] bus_rdata_r;
  logic btn_prog, btn_enter, btn_up, btn_down;
  logic first_switch_output, second_switch_output;
  logic first_indicator, second_indicator, clock_unset_r;
  dsos_state_t state_r;
  logic [1:0] load_on_r;
  logic [7:0] n_close_r;
  logic [31:0] rng = 32'h00018578;
  int n_errors = 0;
  int num_checks = 0;

  dsos_sched dut (.clk_sys, .srst, .btn_prog, .btn_enter, .btn_up, .btn_down,
    .sec_tick, .tod, .time_set, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata_r, .first_switch_output, .second_switch_output,
    .first_indicator, .second_indicator, .clock_unset_r, .state_r);
  dsos_panel panel (.clk_sys, .srst, .press_req,
    .load1_drive(first_switch_output), .load2_drive(second_switch_output),
    .btn_prog, .btn_enter, .btn_up, .btn_down, .load_on_r, .n_close_r);

  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic logic [31:0] stat(input logic [1:0] sw,
                                       input logic unset,
                                       input dsos_state_t st);
    return {24'h0, st, 1'b0, unset, sw};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask

  // Read data live only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata_r, exp);
  endtask

  task automatic press_go(input logic [3:0] m);
    @(posedge clk_sys);
    press_req <= m;
    @(posedge clk_sys);
    press_req <= 4'h0;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic press(input logic [3:0] m, input int n, input dsos_state_t st);
    for (int i = 0; i < n; i++)
      press_go(m);
    chk(32'(state_r), 32'(st));
  endtask

  // Switch, lamp and load must all agree after the tick has landed
  task automatic tick(input logic [16:0] t, input logic [1:0] e);
    @(posedge clk_sys);
    tod <= t;
    sec_tick <= 1'b1;
    @(posedge clk_sys);
    sec_tick <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({second_switch_output, first_switch_output}, 32'(e));
    chk({first_indicator, second_indicator}, {e[0], e[1]});
    chk(32'(load_on_r), 32'(e));
  endtask

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    test_done();
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    rd(4'h0, stat(2'b00, 1'b1, DSOS_S_DISP));
    rd(4'h4, 32'h0);
    wr(4'h8, 32'hffffffff);
    wr(4'h0, 32'h000000ff);
    rd(4'h8, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'h0, stat(2'b00, 1'b1, DSOS_S_DISP));
    press(P | E, 1, DSOS_S_MENU);
    press(P, 1, DSOS_S_SUB);
    press(U, 1, DSOS_S_SUB);
    press(P, 1, DSOS_S_EN);
    press(U, 1, DSOS_S_EN);
    press(E, 1, DSOS_S_SUB);
    press(U, 1, DSOS_S_SUB);
    press(P, 1, DSOS_S_TIME);
    press(U, 2, DSOS_S_TIME);
    press(P, 1, DSOS_S_TIME);
    press(U, 1, DSOS_S_TIME);
    press(P, 1, DSOS_S_TIME);
    press(E, 1, DSOS_S_SUB);
    press(U, 1, DSOS_S_SUB);
    press(P, 1, DSOS_S_TIME);
    press(U, 3, DSOS_S_TIME);
    press(E, 1, DSOS_S_SUB);
    press(E, 1, DSOS_S_MENU);
    press(E, 1, DSOS_S_DISP);
    rd(4'h4, 32'h1);
    // Every enable code, 3 included; pair two sits at midnight
    for (int m = 0; m < 4; m++)
    begin
      wr(4'h4, 32'(m));
      tick(T_ON1, m == 1 || m == 2);
      tick(17'h00000, m == 1);
      tick(T_OFF1, 1'b0);
    end
    wr(4'h4, 32'h1);
    tick(T_ON1, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      rng = xs(rng);
      tick({5'(4 + rng[7:0] % 20), 6'(rng[15:8] % 60), 6'(rng[23:16] % 60)},
           1'b1);
    end
    rd(4'h0, stat(2'b01, 1'b1, DSOS_S_DISP));
    wr(4'h4, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({first_switch_output, first_indicator}, 32'h0);
    chk(32'(n_close_r), 32'h3);
    chk(32'(clock_unset_r), 32'h1);
    @(posedge clk_sys);
    time_set <= 1'b1;
    @(posedge clk_sys);
    time_set <= 1'b0;
    rd(4'h0, stat(2'b00, 1'b0, DSOS_S_DISP));
    chk(32'(clock_unset_r), 32'h0);
    press(P | U, 1, DSOS_S_DISP);
    wr(4'h4, 32'h15);
    press(P | U, 1, DSOS_S_OPSEL);
    press(E, 1, DSOS_S_DISP);
    // Operator code 1, then only the matching code opens the times
    press(P | E, 1, DSOS_S_MENU);
    press(U, 2, DSOS_S_MENU);
    press(P, 1, DSOS_S_SUB);
    press(U, 1, DSOS_S_SUB);
    press(P, 1, DSOS_S_CODE);
    press(U, 1, DSOS_S_CODE);
    press(E, 1, DSOS_S_SUB);
    press(E, 2, DSOS_S_DISP);
    press(P | U, 1, DSOS_S_OPCODE);
    press(E, 1, DSOS_S_DISP);
    press(P | U, 1, DSOS_S_OPCODE);
    press(U, 1, DSOS_S_OPCODE);
    press(E, 1, DSOS_S_OPSEL);
    // Hidden second-pair slots of output one are skipped on the way
    press(U, 2, DSOS_S_OPSEL);
    press(P, 1, DSOS_S_TIME);
    press(U, 1, DSOS_S_TIME);
    press(E, 1, DSOS_S_OPSEL);
    press(E, 1, DSOS_S_DISP);
    tick({5'h01, 6'h00, 6'h00}, 2'b10);
    tick(17'h00000, 2'b00);
    // Lock code with characters at positions 0 and 1
    press(P | E, 1, DSOS_S_MENU);
    press(D, 1, DSOS_S_MENU);
    press(P, 1, DSOS_S_CODE);
    press(U, 1, DSOS_S_CODE);
    press(P, 1, DSOS_S_CODE);
    press(U, 1, DSOS_S_CODE);
    for (int i = 0; i < 4 && state_r !== DSOS_S_DISP; i++)
      press_go(E);
    chk(32'(state_r), 32'(DSOS_S_DISP));
    press(P | E, 1, DSOS_S_LOCK);
    press(U, 1, DSOS_S_LOCK);
    press(E, 1, DSOS_S_DISP);
    press(P | E, 1, DSOS_S_LOCK);
    press(U, 1, DSOS_S_LOCK);
    press(P, 1, DSOS_S_LOCK);
    press(U, 1, DSOS_S_LOCK);
    press(E, 1, DSOS_S_MENU);
    press(E, 1, DSOS_S_DISP);
    for (int i = 0; i < 8; i++)
    begin
      rng = xs(rng);
      wr(4'h4, rng);
      rd(4'h4, {27'h0, rng[4:0]});
    end
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(4'h0, stat(2'b00, 1'b1, DSOS_S_DISP));
    rd(4'h4, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
